// >>> design/sadc_scan_ctrl.sv
// sadc_scan_ctrl.sv: APB slave, scan sequencing, strobe, word packing
// assumes: converter results valid at busy rising edge; pins synchronous to pclk
//
// Added by the designer: the address map and register access over APB.
`include "sadc_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module sadc_scan_ctrl #(
    parameter int CH  = 4,
    parameter int AW  = 4,
    parameter int CW  = 24
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          internal_clk_in,
    input  wire logic          external_base_clock_in,
    input  wire logic          converter_busy_n,
    input  wire logic [15:0]   conv_result,
    input  wire logic [CH*2-1:0] sync_digital_bits,
    output logic               conversion_strobe,
    output logic [CH*4-1:0]    channel_range,
    output logic [1:0]         result_channel
);
    sadc_pkg::sadc_state_t state;
    sadc_pkg::sadc_state_t next_state;
    logic          scan_mode;
    logic          use_ext;
    logic          v14;
    logic [CW-1:0] interval;
    logic [CW-1:0] post_scan_count;
    logic [CW-1:0] scans_left;
    logic [CH*4-1:0] chcfg;
    logic [15:0]   hold;
    logic [CH*2-1:0] sdi_q;
    logic          data_ready;
    logic          acq_run;
    logic [2:0]    strobe_cnt;
    logic [1:0]    chan;
    logic          busy_d;
    logic          busy_rise;
    logic          scan_begin;
    logic          wr_acc;
    logic          rd_acc;
    logic          sw_start;
    logic          sw_trig;
    logic          sw_stop;
    logic          fifo_pop;
    logic [15:0]   fifo_rd;
    logic          fifo_empty;
    logic          fifo_full;
    logic          fifo_wr;
    logic [15:0]   word;
    logic [31:0]   next_prdata;

    assign wr_acc    = psel && penable && pwrite && pready;
    assign rd_acc    = psel && penable && !pwrite && pready;
    assign sw_start  = wr_acc && paddr == `SADC_CMD_OFS && pwdata[`SADC_CMD_START_BIT];
    assign sw_trig   = wr_acc && paddr == `SADC_CMD_OFS && pwdata[`SADC_CMD_TRIG_BIT];
    assign sw_stop   = wr_acc && paddr == `SADC_CMD_OFS && pwdata[`SADC_CMD_STOP_BIT];
    assign fifo_pop  = rd_acc && paddr == `SADC_FIFO_OFS;
    assign busy_rise = converter_busy_n && !busy_d;

    // 14-bit result in 15..2, digital bits of this channel in 1..0; else 16-bit binary
    always_comb begin
        word = conv_result;
        if (v14 && state == sadc_pkg::SADC_BUSY) begin
            word = {conv_result[13:0], sync_digital_bits[chan*2 +: 2]};
        end else if (v14) begin
            word = {conv_result[13:0], sdi_q[chan*2 +: 2]};
        end
    end

    assign fifo_wr = (state == sadc_pkg::SADC_STORE);

    sadc_counter_base_clock #(.CW(CW)) u_counter_base_clock (
        .pclk                   (pclk),
        .presetn                (presetn),
        .use_external           (use_ext),
        .internal_clk_in        (internal_clk_in),
        .external_base_clock_in (external_base_clock_in),
        .run                    (acq_run),
        .interval               (interval),
        .scan_begin             (scan_begin)
    );

    sadc_fifo #(.W(16), .AW(AW)) u_fifo (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (fifo_wr),
        .wr_data (hold),
        .rd_en   (fifo_pop),
        .rd_data (fifo_rd),
        .empty   (fifo_empty),
        .full    (fifo_full)
    );

    // registers software writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_mode       <= 1'b0;
            use_ext         <= 1'b0;
            v14             <= 1'b1;
            interval        <= `SADC_INTERVAL_RESET;
            post_scan_count <= '0;
            chcfg           <= `SADC_CHCFG_RESET;
        end else if (wr_acc) begin
            unique case (paddr)
                `SADC_CTRL_OFS: begin
                    scan_mode <= pwdata[`SADC_CTRL_SCAN_BIT];
                    use_ext   <= pwdata[`SADC_CTRL_EXT_BIT];
                    v14       <= pwdata[`SADC_CTRL_V14_BIT];
                end
                `SADC_INTERVAL_OFS: interval <= pwdata[CW-1:0];
                `SADC_POSTSCAN_OFS: post_scan_count <= pwdata[CW-1:0];
                `SADC_CHCFG_OFS: chcfg <= pwdata[CH*4-1:0];
                default: ;
            endcase
        end
    end

    // per channel: bits 1..0 span, bit 2 unipolar, bit 3 disabled; held until rewritten
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_range <= `SADC_CHCFG_RESET;
        end else begin
            channel_range <= chcfg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_d <= 1'b1;
        end else begin
            busy_d <= converter_busy_n;
        end
    end

    // sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            sadc_pkg::SADC_IDLE: begin
                if (sw_start && !scan_mode) begin
                    next_state = sadc_pkg::SADC_STROBE;
                end else if (acq_run) begin
                    next_state = sadc_pkg::SADC_ARMED;
                end
            end
            sadc_pkg::SADC_ARMED: begin
                if (!acq_run) begin
                    next_state = sadc_pkg::SADC_IDLE;
                end else if (scan_begin) begin
                    next_state = sadc_pkg::SADC_STROBE;
                end
            end
            sadc_pkg::SADC_STROBE: begin
                if (strobe_cnt == 3'(`SADC_STROBE_CYC - 1)) begin
                    next_state = sadc_pkg::SADC_BUSY;
                end
            end
            sadc_pkg::SADC_BUSY: begin
                if (busy_rise) begin
                    next_state = sadc_pkg::SADC_STORE;
                end
            end
            // four store cycles: the FIFO takes hold one cycle behind the channel walk
            sadc_pkg::SADC_STORE: begin
                if (chan != 2'h0) begin
                    next_state = sadc_pkg::SADC_STORE;
                end else if (acq_run) begin
                    next_state = sadc_pkg::SADC_ARMED;
                end else begin
                    next_state = sadc_pkg::SADC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= sadc_pkg::SADC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_cnt        <= '0;
            conversion_strobe <= 1'b0;
        end else begin
            conversion_strobe <= (next_state == sadc_pkg::SADC_STROBE);
            if (state == sadc_pkg::SADC_STROBE) begin
                strobe_cnt <= strobe_cnt + 3'h1;
            end else begin
                strobe_cnt <= '0;
            end
        end
    end

    // acquisition run: starts on trigger, counts scans down to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acq_run    <= 1'b0;
            scans_left <= '0;
        end else if (sw_stop || !scan_mode) begin
            acq_run <= 1'b0;
        end else if (!acq_run && sw_trig && post_scan_count != '0) begin
            acq_run    <= 1'b1;
            scans_left <= post_scan_count;
        end else if (acq_run && scan_begin && state == sadc_pkg::SADC_ARMED) begin
            scans_left <= scans_left - {{(CW-1){1'b0}}, 1'b1};
            if (scans_left == {{(CW-1){1'b0}}, 1'b1}) begin
                acq_run <= 1'b0;
            end
        end
    end

    // channel walk over the simultaneous results, wrapping to 0 after the last
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan           <= '0;
            result_channel <= '0;
        end else if (state == sadc_pkg::SADC_BUSY && busy_rise) begin
            chan           <= 2'h1;
            result_channel <= 2'h1;
        end else if (state == sadc_pkg::SADC_STORE && chan != 2'h0) begin
            chan           <= chan + 2'h1;
            result_channel <= chan + 2'h1;
        end else if (state != sadc_pkg::SADC_STORE) begin
            chan           <= '0;
            result_channel <= '0;
        end
    end

    // holding register: ch0 at the busy edge, then one channel per cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold <= '0;
        end else if ((state == sadc_pkg::SADC_BUSY && busy_rise) ||
                     (state == sadc_pkg::SADC_STORE && chan != 2'h0)) begin
            hold <= word;
        end
    end

    // digital bits of every channel latched at the busy edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sdi_q <= '0;
        end else if (state == sadc_pkg::SADC_BUSY && busy_rise) begin
            sdi_q <= sync_digital_bits;
        end
    end

    // poll flag: set by a push, cleared by a holding read; set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_ready <= 1'b0;
        end else if (fifo_wr) begin
            data_ready <= 1'b1;
        end else if (rd_acc && paddr == `SADC_HOLD_OFS) begin
            data_ready <= 1'b0;
        end
    end

    // read mux
    always_comb begin
        next_prdata = 32'h0000_0000;
        unique case (paddr)
            `SADC_CTRL_OFS:     next_prdata = {29'h0, v14, use_ext, scan_mode};
            `SADC_STATUS_OFS:   next_prdata = {26'h0, fifo_full, fifo_empty,
                                               (state != sadc_pkg::SADC_IDLE),
                                               acq_run, 1'b0, data_ready};
            `SADC_INTERVAL_OFS: next_prdata = {8'h00, interval};
            `SADC_POSTSCAN_OFS: next_prdata = {8'h00, scans_left};
            `SADC_CHCFG_OFS:    next_prdata = {16'h0000, chcfg};
            `SADC_HOLD_OFS:     next_prdata = {16'h0000, hold};
            `SADC_FIFO_OFS:     next_prdata = {16'h0000, fifo_rd};
            default:            next_prdata = 32'h0000_0000;
        endcase
    end

    // one wait state: pready in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && (paddr[1:0] != 2'h0 ||
                       paddr > `SADC_CMD_OFS);
            prdata  <= (psel && penable && !pready) ? next_prdata : 32'h0000_0000;
        end
    end
endmodule // sadc_scan_ctrl
`default_nettype wire

// >>> design/sadc_regs.svh
// sadc_regs.svh: register offsets, fields, reset values and timing counts
// assumes: included by bare name from the scan control, its base clock counter, the checker and the bench
// Function
// - 14-bit variant packs result with two digital bits
// - result in bits 15..2, digital bits 1..0
// - each word goes to holding register and FIFO
// - digital bits captured on busy rising edge
// - bipolar 14-bit codes are two's complement
// - unipolar 14-bit codes use same pattern
// - 16-bit variant codes are straight binary
// - software start fires exactly one conversion
// - per-channel range settings held until changed
// - spans 10/5/2.5/1.25 V, bipolar/unipolar, or off
// - 24-bit scan-interval counter sets scan period
// - 24-bit post-scan counter ends acquisition
// - one strobe samples all four channels
// - scan-interval terminal count makes strobe
// - base clock selects internal or external pin
// - scan acquisition waits for trigger
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH
`define SADC_CTRL_OFS       12'h000
`define SADC_STATUS_OFS     12'h004
`define SADC_INTERVAL_OFS   12'h008
`define SADC_POSTSCAN_OFS   12'h00c
`define SADC_CHCFG_OFS      12'h010
`define SADC_HOLD_OFS       12'h014
`define SADC_FIFO_OFS       12'h018
`define SADC_CMD_OFS        12'h01c
`define SADC_CTRL_SCAN_BIT  0
`define SADC_CTRL_EXT_BIT   1
`define SADC_CTRL_V14_BIT   2
`define SADC_CMD_START_BIT  0
`define SADC_CMD_TRIG_BIT   1
`define SADC_CMD_STOP_BIT   2
`define SADC_CHCFG_RESET    16'h0000
`define SADC_INTERVAL_RESET 24'h000050
`define SADC_STROBE_NS      40
`define SADC_CLK_NS         8
`define SADC_STROBE_CYC     ((`SADC_STROBE_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`endif

// >>> design/sadc_pkg.sv
// sadc_pkg.sv: types for the scan control
// assumes: nothing beyond the tool's SystemVerilog support
package sadc_pkg;
    typedef enum logic [4:0] {
        SADC_IDLE   = 5'b00001,
        SADC_ARMED  = 5'b00010,
        SADC_STROBE = 5'b00100,
        SADC_BUSY   = 5'b01000,
        SADC_STORE  = 5'b10000
    } sadc_state_t;
    typedef enum logic [1:0] {
        SADC_SPAN_10  = 2'h0,
        SADC_SPAN_5   = 2'h1,
        SADC_SPAN_2P5 = 2'h2,
        SADC_SPAN_1P25 = 2'h3
    } sadc_span_t;
endpackage

// >>> design/sadc_counter_base_clock.sv
// sadc_counter_base_clock.sv: selected base clock edge detect and scan-interval counter
// assumes: base clock pins synchronous to pclk and slower than pclk / 2
`include "sadc_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module sadc_counter_base_clock #(
    parameter int CW = 24
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          use_external,
    input  wire logic          internal_clk_in,
    input  wire logic          external_base_clock_in,
    input  wire logic          run,
    input  wire logic [CW-1:0] interval,
    output logic               scan_begin
);
    logic          base_d;
    logic          counter_base_clock;
    logic          base_tick;
    logic [CW-1:0] count;

    assign counter_base_clock = use_external ? external_base_clock_in : internal_clk_in;
    assign base_tick = counter_base_clock & ~base_d;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_d <= 1'b0;
        end else begin
            base_d <= counter_base_clock;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count      <= '0;
            scan_begin <= 1'b0;
        end else begin
            scan_begin <= 1'b0;
            if (!run) begin
                count <= '0;
            end else if (base_tick) begin
                if (count <= {{(CW-1){1'b0}}, 1'b1}) begin
                    count      <= interval;
                    scan_begin <= 1'b1;
                end else begin
                    count <= count - {{(CW-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // sadc_counter_base_clock
`default_nettype wire

// >>> design/sadc_fifo.sv
// sadc_fifo.sv: data FIFO for conversion words
// assumes: reader pops with rd_en only while not empty
`timescale 1ns/100ps
`default_nettype none
module sadc_fifo #(
    parameter int W  = 16,
    parameter int AW = 4
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    input  wire logic         rd_en,
    output logic [W-1:0]      rd_data,
    output logic              empty,
    output logic              full
);
    logic [W-1:0] mem [0:(1<<AW)-1];
    logic [AW:0]  wp;
    logic [AW:0]  rp;

    assign empty   = (wp == rp);
    assign full    = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
    assign rd_data = mem[rp[AW-1:0]];

    always_ff @(posedge pclk) begin
        if (wr_en && !full) begin
            mem[wp[AW-1:0]] <= wr_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp <= '0;
            rp <= '0;
        end else begin
            if (wr_en && !full) begin
                wp <= wp + {{AW{1'b0}}, 1'b1};
            end
            if (rd_en && !empty) begin
                rp <= rp + {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // sadc_fifo
`default_nettype wire

// >>> bench/sadc_scan_ctrl_checker.sv
// sadc_scan_ctrl_checker.sv: port assertions for the scan control
// assumes: bound to sadc_scan_ctrl, single pclk domain
`include "sadc_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module sadc_scan_ctrl_checker #(
    parameter int CH = 4,
    parameter int AW = 4,
    parameter int CW = 24
) (
    input wire logic            pclk,
    input wire logic            presetn,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [11:0]     paddr,
    input wire logic [31:0]     pwdata,
    input wire logic            pready,
    input wire logic            pslverr,
    input wire logic            conversion_strobe,
    input wire logic [CH*4-1:0] channel_range
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic chcfg_wr;
    assign chcfg_wr = psel && penable && pwrite && pready && paddr == `SADC_CHCFG_OFS;
    wait_state_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    err_unmapped_a: assert property (pready && (paddr > 12'h01c || paddr[1:0] != 2'h0) |-> pslverr)
        else $error("bad address not refused");
    strobe_width_a: assert property ($rose(conversion_strobe) |->
        conversion_strobe[*5] ##1 !conversion_strobe)
        else $error("strobe width wrong");
    range_hold_a: assert property (!chcfg_wr ##1 !chcfg_wr |=> $stable(channel_range))
        else $error("channel range changed without write");
    range_write_a: assert property (chcfg_wr |-> ##2 channel_range == $past(pwdata[CH*4-1:0], 2))
        else $error("channel range not written");
    strobe_c: cover property ($rose(conversion_strobe));
    refuse_c: cover property (pready && pslverr);
    range_c: cover property (chcfg_wr);
endmodule // sadc_scan_ctrl_checker
bind sadc_scan_ctrl sadc_scan_ctrl_checker #(.CH(CH), .AW(AW), .CW(CW)) sadc_scan_ctrl_checker_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .conversion_strobe(conversion_strobe), .channel_range(channel_range)
);
`default_nettype wire

// >>> bench/sadc_conv_model.sv
// sadc_conv_model.sv: behavioural four-channel converter facing the scan control
// assumes: strobe and result channel come from the scan control in the pclk domain
`timescale 1ns/100ps
`default_nettype none
module sadc_conv_model #(
    parameter int BUSY_CYC = 30
) (
    input wire logic        pclk,
    input wire logic        conversion_strobe,
    input wire logic [1:0]  result_channel,
    input wire logic [63:0] codes,
    input wire logic [7:0]  sdi,
    output logic            converter_busy_n,
    output logic [15:0]     conv_result,
    output logic [7:0]      sync_digital_bits
);
    logic strobe_q;
    int   busy_cnt;
    int   hold_cnt;
    initial begin
        strobe_q = 1'b0;
        busy_cnt = 0;
        hold_cnt = 0;
        converter_busy_n = 1'b1;
    end
    // inputs sampled at strobe fall, busy for 240 ns
    always @(posedge pclk) begin
        strobe_q <= conversion_strobe;
        if (strobe_q && !conversion_strobe) begin
            busy_cnt <= BUSY_CYC;
            converter_busy_n <= 1'b0;
        end else if (busy_cnt > 1) begin
            busy_cnt <= busy_cnt - 1;
        end else if (busy_cnt == 1) begin
            busy_cnt <= 0;
            converter_busy_n <= 1'b1;
            hold_cnt <= 1;
        end else if (hold_cnt > 0) begin
            hold_cnt <= hold_cnt - 1;
        end
    end
    // result garbled while converting; digital bits valid one cycle past busy rise
    assign conv_result = converter_busy_n ? codes[result_channel*16 +: 16]
                                          : ~codes[result_channel*16 +: 16];
    assign sync_digital_bits = (!converter_busy_n || hold_cnt > 0) ? sdi : ~sdi;
endmodule // sadc_conv_model
`default_nettype wire

// >>> bench/sadc_scan_ctrl_test.sv
// sadc_scan_ctrl_test.sv: self-checking bench for the scan control over APB
// assumes: sadc_conv_model on the converter side, checker bound to the design
`include "sadc_regs.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    $display("[FAIL] %s expected %h seen %h", n, e, g); fail_count++; end end
module sadc_scan_ctrl_test;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        internal_clk_in;
    logic        external_base_clock_in;
    logic        converter_busy_n;
    logic [15:0] conv_result;
    logic [7:0]  sync_digital_bits;
    logic        conversion_strobe;
    logic [15:0] channel_range;
    logic [1:0]  result_channel;
    logic [63:0] codes;
    logic [7:0]  sdi;
    logic [31:0] rd;
    logic        err;
    logic        strobe_q;
    int          fail_count;
    int          tests_run;
    int          cycles;
    int          strobes;
    int          last_rise;
    int          gap;
    int          acc_int;
    int          acc_ext;
    sadc_scan_ctrl sadc_scan_ctrl_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .internal_clk_in(internal_clk_in), .external_base_clock_in(external_base_clock_in),
        .converter_busy_n(converter_busy_n), .conv_result(conv_result),
        .sync_digital_bits(sync_digital_bits), .conversion_strobe(conversion_strobe),
        .channel_range(channel_range), .result_channel(result_channel)
    );
    sadc_conv_model sadc_conv_model_i (
        .pclk(pclk), .conversion_strobe(conversion_strobe), .result_channel(result_channel),
        .codes(codes), .sdi(sdi), .converter_busy_n(converter_busy_n),
        .conv_result(conv_result), .sync_digital_bits(sync_digital_bits)
    );
    initial pclk = 1'b0;
    always #4 pclk = ~pclk;
    // base clocks stepped on pclk: 40 MHz internal, continuous 10 MHz external
    always @(posedge pclk) begin
        acc_int <= (acc_int + 80) % 125;
        acc_ext <= (acc_ext + 20) % 125;
        if (acc_int + 80 >= 125) internal_clk_in <= ~internal_clk_in;
        if (acc_ext + 20 >= 125) external_base_clock_in <= ~external_base_clock_in;
    end
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        strobe_q <= conversion_strobe;
        if (conversion_strobe && !strobe_q) begin
            strobes <= strobes + 1;
            gap <= cycles - last_rise;
            last_rise <= cycles;
        end
        if (cycles == 30000) begin
            fail_count++;
            end_sim;
        end
    end
    task automatic end_sim;
        if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e,
                        input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        `CHK(n, e & m, rd & m)
    endtask
    function automatic logic [15:0] word(input int k, input logic v14);
        logic [15:0] r;
        r = codes[k*16 +: 16];
        return v14 ? {r[13:0], sdi[2*k +: 2]} : r;
    endfunction
    task automatic poll(input logic v14);
        int n;
        n = strobes;
        apb(1'b1, `SADC_CMD_OFS, 32'h1);
        do apb(1'b0, `SADC_STATUS_OFS, 32'h0); while (rd[0] !== 1'b1);
        repeat (8) @(posedge pclk);
        `CHK("one strobe", n + 1, strobes)
        rchk("hold", `SADC_HOLD_OFS, word(3, v14), 32'hffff);
        rchk("analog", `SADC_HOLD_OFS, word(3, v14), 32'hfffc);
        rchk("ready clear", `SADC_STATUS_OFS, 32'h0, 32'h1);
        for (int k = 0; k < 4; k++) rchk("fifo", `SADC_FIFO_OFS, word(k, v14), 32'hffff);
        rchk("empty", `SADC_STATUS_OFS, 32'h10, 32'h10);
    endtask
    task automatic scan(input logic ext, input int n, input int lo, input int hi);
        apb(1'b1, `SADC_CTRL_OFS, {29'h0, 1'b1, ext, 1'b1});
        apb(1'b1, `SADC_INTERVAL_OFS, 32'd20);
        apb(1'b1, `SADC_POSTSCAN_OFS, n);
        strobes = 0;
        repeat (300) @(posedge pclk);
        `CHK("no trigger", 0, strobes)
        apb(1'b1, `SADC_CMD_OFS, 32'h2);
        repeat ((n + 2) * hi) @(posedge pclk);
        `CHK("scan count", n, strobes)
        `CHK("scan period", 1'b1, gap >= lo && gap <= hi)
        rchk("run over", `SADC_STATUS_OFS, 32'h0, 32'h4);
        rchk("remaining", `SADC_POSTSCAN_OFS, 32'h0, 32'hffffff);
        for (int k = 0; k < 4 * n; k++) begin
            rchk("scan word", `SADC_FIFO_OFS, word(k % 4, 1'b1), 32'hffff);
        end
    endtask
    initial begin
        logic [15:0] v;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        fail_count = 0;
        tests_run = 0;
        cycles = 0;
        strobes = 0;
        last_rise = 0;
        gap = 0;
        strobe_q = 1'b0;
        internal_clk_in = 1'b0;
        external_base_clock_in = 1'b0;
        acc_int = 0;
        acc_ext = 0;
        codes = 64'h2000_3fff_0001_1fff;
        sdi = 8'h9c;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rchk("ctrl reset", `SADC_CTRL_OFS, 32'h4, 32'h7);
        rchk("interval reset", `SADC_INTERVAL_OFS, 32'h50, 32'hffffff);
        rchk("chcfg reset", `SADC_CHCFG_OFS, 32'h0, 32'hffff);
        rchk("status reset", `SADC_STATUS_OFS, 32'h10, 32'h3d);
        apb(1'b0, 12'h020, 32'h0);
        `CHK("unmapped", 1'b1, err)
        apb(1'b1, 12'h002, 32'hffff);
        `CHK("unaligned", 1'b1, err)
        for (int k = 0; k < 4; k++) begin
            for (int c = 0; c < 4; c++) v[4*c +: 4] = {c == 2, c[0] ^ k[0], 2'((k + c) % 4)};
            apb(1'b1, `SADC_CHCFG_OFS, {16'h0, v});
            repeat (2) @(posedge pclk);
            `CHK("range out", v, channel_range)
            rchk("range read", `SADC_CHCFG_OFS, {16'h0, v}, 32'hffff);
        end
        apb(1'b1, `SADC_CHCFG_OFS, 32'h0123);
        poll(1'b1);
        apb(1'b1, `SADC_CTRL_OFS, 32'h0);
        codes <= 64'hffff_8001_8000_0000;
        poll(1'b0);
        codes <= 64'h7fff_1fff_0000_2000;
        scan(1'b0, 3, 60, 65);
        scan(1'b1, 2, 248, 252);
        apb(1'b1, `SADC_POSTSCAN_OFS, 32'h4);
        strobes = 0;
        apb(1'b1, `SADC_CMD_OFS, 32'h2);
        repeat (300) @(posedge pclk);
        apb(1'b1, `SADC_CMD_OFS, 32'h4);
        rchk("stopped", `SADC_STATUS_OFS, 32'h0, 32'h4);
        repeat (600) @(posedge pclk);
        `CHK("stop count", 2, strobes)
        end_sim;
    end
endmodule // sadc_scan_ctrl_test
`default_nettype wire
